// [rtl/ldcr_channel.sv]
// One LDO channel: voltage select and control registers
`timescale 1ns/10ps
`default_nettype none
`include "ldcr_params.svh"
module ldcr_channel (
   input wire logic i_clk, // System clock
   input wire logic i_nrst, // Synchronous reset, active low
   input wire logic i_wr_vsel, // Write voltage select, one cycle
   input wire logic i_wr_ctrl, // Write control, one cycle
   input wire logic [7:0] i_wdata, // Write byte
   input wire logic i_power_ok, // Power-good comparator, async
   input wire logic i_fault, // Fault flag, async
   output logic [7:0] o_vsel_rd, // Voltage select readback
   output logic [7:0] o_ctrl_rd, // Control readback
   output logic o_enable, // Regulator enable
   output logic o_discharge, // Discharge path on
   output logic o_low_q, // Low-power mode select
   output logic [2:0] o_delay, // Turn-on delay select
   output logic [5:0] o_voltage_code, // Output voltage code
   output logic o_fault_irq // Masked fault request
);
   logic [5:0] voltage_code_reg;
   logic [7:1] ctrl_reg;
   logic [1:0] pok_sync_reg;
   logic [1:0] fault_sync_reg;

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         pok_sync_reg <= 2'h0;
         fault_sync_reg <= 2'h0;
      end else begin
         pok_sync_reg <= {pok_sync_reg[0], i_power_ok};
         fault_sync_reg <= {fault_sync_reg[0], i_fault};
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         voltage_code_reg <= `LDCR_VSEL_RESET;
      end else if (i_wr_vsel) begin
         voltage_code_reg <= i_wdata[`LDCR_VSEL_CODE_MSB:`LDCR_VSEL_CODE_LSB];
      end
   end

   // Power-OK bit is status only, write ignored
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         ctrl_reg <= `LDCR_CTRL_RESET;
      end else if (i_wr_ctrl) begin
         ctrl_reg <= i_wdata[7:1];
      end
   end

   always_comb begin
      o_vsel_rd = {2'h0, voltage_code_reg};
      o_ctrl_rd = {ctrl_reg, pok_sync_reg[1]};
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_enable <= 1'b0;
         o_discharge <= 1'b0;
         o_low_q <= 1'b0;
         o_delay <= 3'h0;
         o_voltage_code <= 6'h00;
         o_fault_irq <= 1'b0;
      end else begin
         o_enable <= ctrl_reg[`LDCR_CTRL_ENABLE_BIT];
         o_discharge <= ctrl_reg[`LDCR_CTRL_DISCHARGE_BIT]
            & ~ctrl_reg[`LDCR_CTRL_ENABLE_BIT];
         o_low_q <= ctrl_reg[`LDCR_CTRL_LOW_Q_BIT];
         o_delay <= ctrl_reg[`LDCR_CTRL_DELAY_MSB:`LDCR_CTRL_DELAY_LSB];
         o_voltage_code <= voltage_code_reg;
         o_fault_irq <= fault_sync_reg[1] & ctrl_reg[`LDCR_CTRL_FAULT_ALLOW_BIT];
      end
   end
endmodule : ldcr_channel
`default_nettype wire

// [rtl/ldcr_params.svh]
// Constants for the LDO channel control register bank
`ifndef LDCR_PARAMS_SVH
`define LDCR_PARAMS_SVH

// Register offsets, channels a to d
`define LDCR_LDO_A_VOLTAGE_SELECT 8'h50
`define LDCR_LDO_A_CONTROL 8'h51
`define LDCR_LDO_B_VOLTAGE_SELECT 8'h54
`define LDCR_LDO_B_CONTROL 8'h55
`define LDCR_LDO_C_VOLTAGE_SELECT 8'h60
`define LDCR_LDO_C_CONTROL 8'h61
`define LDCR_LDO_D_VOLTAGE_SELECT 8'h64
`define LDCR_LDO_D_CONTROL 8'h65

// Control register fields
`define LDCR_CTRL_ENABLE_BIT 7
`define LDCR_CTRL_DISCHARGE_BIT 6
`define LDCR_CTRL_LOW_Q_BIT 5
`define LDCR_CTRL_DELAY_MSB 4
`define LDCR_CTRL_DELAY_LSB 2
`define LDCR_CTRL_FAULT_ALLOW_BIT 1
`define LDCR_CTRL_POWER_OK_BIT 0

// Voltage select register fields
`define LDCR_VSEL_CODE_MSB 5
`define LDCR_VSEL_CODE_LSB 0

// Reset values
`define LDCR_VSEL_RESET 6'h00
`define LDCR_CTRL_RESET 7'h00
`define LDCR_UNMAPPED_READ 8'h00

// Serial slave address, value arbitrary
`define LDCR_DEVICE_ADDR 7'h2A

`endif

// [rtl/ldcr_pkg.sv]
// Types for the LDO channel control register bank
`default_nettype none
package ldcr_pkg;
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_REG = 7'h04,
      ST_WDATA = 7'h08,
      ST_ACK = 7'h10,
      ST_RDATA = 7'h20,
      ST_MACK = 7'h40
   } ldcr_state_t;
endpackage : ldcr_pkg
`default_nettype wire

// [rtl/ldcr_top.sv]
// Serial slave and register bank for four LDO channels
// Functional notes
// - Channel enable bit one turns the regulator on, zero turns it off.
// - Discharge bit one discharges a disabled channel's output; zero never discharges.
// - Low-quiescent bit one selects low-power mode, zero normal mode.
// - Three-bit read/write field per channel selects turn-on delay.
// - Faults raise an interrupt only while the fault-allow bit is one.
// - Power-OK bit reads one while output is above power-good threshold.
// - Six-bit read/write voltage code in low bits; upper two reserved.
`timescale 1ns/10ps
`default_nettype none
`include "ldcr_params.svh"
module ldcr_top #(
   parameter int NUM_CH = 4 // Number of LDO channels
) (
   input wire logic i_clk, // System clock, 100 MHz
   input wire logic i_nrst, // Synchronous reset, active low
   input wire logic i_scl, // Serial clock pin
   input wire logic i_sda, // Serial data pin, input side
   output logic o_sda, // Serial data output value, always low
   output logic o_sda_oe, // Serial data pull-low enable
   input wire logic [NUM_CH-1:0] i_ldo_power_ok, // Power-good per channel
   input wire logic [NUM_CH-1:0] i_ldo_fault, // Fault per channel
   output logic [NUM_CH-1:0] o_ldo_enable, // Regulator enable
   output logic [NUM_CH-1:0] o_ldo_discharge, // Discharge path on
   output logic [NUM_CH-1:0] o_ldo_low_quiescent, // Low-power mode
   output logic [3*NUM_CH-1:0] o_ldo_delay, // Turn-on delay fields
   output logic [6*NUM_CH-1:0] o_ldo_voltage_code, // Voltage codes
   output logic [NUM_CH-1:0] o_ldo_fault_irq // Masked fault requests
);
   localparam logic [7:0] VSEL_ADDR [0:3] = '{`LDCR_LDO_A_VOLTAGE_SELECT,
      `LDCR_LDO_B_VOLTAGE_SELECT, `LDCR_LDO_C_VOLTAGE_SELECT, `LDCR_LDO_D_VOLTAGE_SELECT};
   localparam logic [7:0] CTRL_ADDR [0:3] = '{`LDCR_LDO_A_CONTROL,
      `LDCR_LDO_B_CONTROL, `LDCR_LDO_C_CONTROL, `LDCR_LDO_D_CONTROL};

   ldcr_pkg::ldcr_state_t state_reg;
   ldcr_pkg::ldcr_state_t after_ack_reg;
   logic [2:0] scl_sync_reg;
   logic [2:0] sda_sync_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] ptr_reg;
   logic mack_reg;
   logic wr_stb_reg;
   logic [7:0] wr_addr_reg;
   logic [7:0] wr_data_reg;
   logic [7:0] rdata;
   logic [7:0] vsel_rd [NUM_CH];
   logic [7:0] ctrl_rd [NUM_CH];
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   // Pin synchronisers; stage 0 is read only by stage 1
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
      end else begin
         scl_sync_reg <= {scl_sync_reg[1:0], i_scl};
         sda_sync_reg <= {sda_sync_reg[1:0], i_sda};
      end
   end

   always_comb begin
      scl_s = scl_sync_reg[1];
      sda_s = sda_sync_reg[1];
      scl_rise = scl_s & ~scl_sync_reg[2];
      scl_fall = ~scl_s & scl_sync_reg[2];
      bus_start = scl_s & scl_sync_reg[2] & sda_sync_reg[2] & ~sda_s;
      bus_stop = scl_s & scl_sync_reg[2] & ~sda_sync_reg[2] & sda_s;
   end

   // Read data for the current pointer; unmapped reads zero
   always_comb begin
      rdata = `LDCR_UNMAPPED_READ;
      for (int k = 0; k < NUM_CH; k++) begin
         if (ptr_reg == VSEL_ADDR[k]) begin
            rdata = vsel_rd[k];
         end
         if (ptr_reg == CTRL_ADDR[k]) begin
            rdata = ctrl_rd[k];
         end
      end
   end

   // Serial protocol engine
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         state_reg <= ldcr_pkg::ST_IDLE;
         after_ack_reg <= ldcr_pkg::ST_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         ptr_reg <= 8'h00;
         mack_reg <= 1'b0;
         o_sda_oe <= 1'b0;
         wr_stb_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         wr_data_reg <= 8'h00;
      end else begin
         wr_stb_reg <= 1'b0;
         if (bus_start) begin
            state_reg <= ldcr_pkg::ST_ADDR;
            bit_cnt_reg <= 4'h0;
            o_sda_oe <= 1'b0;
         end else if (bus_stop) begin
            state_reg <= ldcr_pkg::ST_IDLE;
            o_sda_oe <= 1'b0;
         end else begin
            case (state_reg)
               ldcr_pkg::ST_ADDR, ldcr_pkg::ST_REG, ldcr_pkg::ST_WDATA: begin
                  if (scl_rise && bit_cnt_reg != 4'h8) begin
                     shift_reg <= {shift_reg[6:0], sda_s};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                     bit_cnt_reg <= 4'h0;
                     state_reg <= ldcr_pkg::ST_ACK;
                     o_sda_oe <= 1'b1;
                     if (state_reg == ldcr_pkg::ST_ADDR) begin
                        if (shift_reg[7:1] != `LDCR_DEVICE_ADDR) begin
                           state_reg <= ldcr_pkg::ST_IDLE;
                           o_sda_oe <= 1'b0;
                        end
                        after_ack_reg <= shift_reg[0] ? ldcr_pkg::ST_RDATA
                                                      : ldcr_pkg::ST_REG;
                     end else if (state_reg == ldcr_pkg::ST_REG) begin
                        ptr_reg <= shift_reg;
                        after_ack_reg <= ldcr_pkg::ST_WDATA;
                     end else begin
                        wr_stb_reg <= 1'b1;
                        wr_addr_reg <= ptr_reg;
                        wr_data_reg <= shift_reg;
                        ptr_reg <= ptr_reg + 8'h01;
                        after_ack_reg <= ldcr_pkg::ST_WDATA;
                     end
                  end
               end
               ldcr_pkg::ST_ACK: begin
                  if (scl_fall) begin
                     state_reg <= after_ack_reg;
                     bit_cnt_reg <= 4'h0;
                     shift_reg <= rdata;
                     o_sda_oe <= (after_ack_reg == ldcr_pkg::ST_RDATA) ? ~rdata[7] : 1'b0;
                  end
               end
               ldcr_pkg::ST_RDATA: begin
                  if (scl_fall) begin
                     if (bit_cnt_reg == 4'h7) begin
                        o_sda_oe <= 1'b0;
                        state_reg <= ldcr_pkg::ST_MACK;
                        mack_reg <= 1'b0;
                     end else begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        o_sda_oe <= ~shift_reg[6];
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     end
                  end
               end
               ldcr_pkg::ST_MACK: begin
                  if (scl_rise) begin
                     if (sda_s) begin
                        state_reg <= ldcr_pkg::ST_IDLE;
                     end else begin
                        mack_reg <= 1'b1;
                        ptr_reg <= ptr_reg + 8'h01;
                     end
                  end else if (scl_fall && mack_reg) begin
                     state_reg <= ldcr_pkg::ST_RDATA;
                     bit_cnt_reg <= 4'h0;
                     shift_reg <= rdata;
                     o_sda_oe <= ~rdata[7];
                  end
               end
               ldcr_pkg::ST_IDLE: begin
                  o_sda_oe <= 1'b0;
               end
               default: begin
                  state_reg <= ldcr_pkg::ST_IDLE;
                  o_sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   assign o_sda = 1'b0;

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         ldcr_channel u_ch (
            .i_clk(i_clk),
            .i_nrst(i_nrst),
            .i_wr_vsel(wr_stb_reg && wr_addr_reg == VSEL_ADDR[g]),
            .i_wr_ctrl(wr_stb_reg && wr_addr_reg == CTRL_ADDR[g]),
            .i_wdata(wr_data_reg),
            .i_power_ok(i_ldo_power_ok[g]),
            .i_fault(i_ldo_fault[g]),
            .o_vsel_rd(vsel_rd[g]),
            .o_ctrl_rd(ctrl_rd[g]),
            .o_enable(o_ldo_enable[g]),
            .o_discharge(o_ldo_discharge[g]),
            .o_low_q(o_ldo_low_quiescent[g]),
            .o_delay(o_ldo_delay[3*g +: 3]),
            .o_voltage_code(o_ldo_voltage_code[6*g +: 6]),
            .o_fault_irq(o_ldo_fault_irq[g])
         );
      end
   endgenerate
endmodule : ldcr_top
`default_nettype wire

// [verification/ldcr_checker.sv]
// Port-level assertions for the LDO register bank
`timescale 1ns/10ps
`default_nettype none
module ldcr_checker #(
   parameter int NUM_CH = 4 // Channels
) (
   input wire logic i_clk, // Clock
   input wire logic i_nrst, // Reset
   input wire logic i_scl, // Serial clock
   input wire logic i_sda, // Serial data
   input wire logic o_sda, // Data value
   input wire logic o_sda_oe, // Data pull
   input wire logic [NUM_CH-1:0] i_ldo_power_ok, // Power good
   input wire logic [NUM_CH-1:0] i_ldo_fault, // Faults
   input wire logic [NUM_CH-1:0] o_ldo_enable, // Enables
   input wire logic [NUM_CH-1:0] o_ldo_discharge, // Discharge
   input wire logic [NUM_CH-1:0] o_ldo_low_quiescent, // Low power
   input wire logic [3*NUM_CH-1:0] o_ldo_delay, // Delays
   input wire logic [6*NUM_CH-1:0] o_ldo_voltage_code, // Codes
   input wire logic [NUM_CH-1:0] o_ldo_fault_irq // Fault requests
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // Settings move only while a written byte is being acknowledged
   property p_en; $changed(o_ldo_enable) |-> o_sda_oe; endproperty
   a_en: assert property (p_en) else $error("enable moved outside a write");
   property p_dis_off; (o_ldo_discharge & o_ldo_enable) == '0; endproperty
   a_dis_off: assert property (p_dis_off) else $error("discharge on enabled channel");
   property p_dis; $changed(o_ldo_discharge) |-> o_sda_oe; endproperty
   a_dis: assert property (p_dis) else $error("discharge moved outside a write");
   property p_lq; $changed(o_ldo_low_quiescent) |-> o_sda_oe; endproperty
   a_lq: assert property (p_lq) else $error("low power moved outside a write");
   property p_dly; $changed(o_ldo_delay) |-> o_sda_oe; endproperty
   a_dly: assert property (p_dly) else $error("delay moved outside a write");
   property p_irq;
      (o_ldo_fault_irq & ~($past(i_ldo_fault, 2) | $past(i_ldo_fault, 3)
         | $past(i_ldo_fault, 4))) == '0;
   endproperty
   a_irq: assert property (p_irq) else $error("fault request without fault");
   property p_irq_why;
      $changed(o_ldo_fault_irq) |-> o_sda_oe || ($past(i_ldo_fault, 1) != $past(i_ldo_fault, 5));
   endproperty
   a_irq_why: assert property (p_irq_why) else $error("fault request moved uncaused");
   property p_vc; $changed(o_ldo_voltage_code) |-> o_sda_oe; endproperty
   a_vc: assert property (p_vc) else $error("voltage code moved outside a write");
   c_en: cover property ($rose(|o_ldo_enable));
   c_dis: cover property ($rose(|o_ldo_discharge));
   c_irq: cover property ($rose(|o_ldo_fault_irq));
endmodule : ldcr_checker
bind ldcr_top ldcr_checker #(.NUM_CH(NUM_CH)) chk_u (.i_clk(i_clk), .i_nrst(i_nrst),
   .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
   .i_ldo_power_ok(i_ldo_power_ok), .i_ldo_fault(i_ldo_fault), .o_ldo_enable(o_ldo_enable),
   .o_ldo_discharge(o_ldo_discharge), .o_ldo_low_quiescent(o_ldo_low_quiescent),
   .o_ldo_delay(o_ldo_delay), .o_ldo_voltage_code(o_ldo_voltage_code),
   .o_ldo_fault_irq(o_ldo_fault_irq));
`default_nettype wire

// [verification/ldcr_host.sv]
// Host serial master model with pull-up on the data wire
`timescale 1ns/10ps
`default_nettype none
module ldcr_host (
   input wire logic i_clk, // Clock
   input wire logic i_pull, // Device pulls data low
   output logic o_scl, // Serial clock
   output wire logic o_sda // Resolved data wire
);
   logic drv = 1'b1;
   initial o_scl = 1'b1;
   assign o_sda = drv & ~i_pull;
   task automatic hc(input int n);
      repeat (n) @(negedge i_clk);
   endtask : hc
   // Start is (1,0) and leaves the clock low; stop is (0,1)
   task automatic frame_edge(input logic a, input logic b);
      hc(5);
      drv = a;
      hc(3);
      o_scl = 1'b1;
      hc(6);
      drv = b;
      hc(6);
      if (!b) o_scl = 1'b0;
   endtask : frame_edge
   task automatic bit_io(input logic b, output logic r);
      hc(5);
      drv = b;
      hc(3);
      o_scl = 1'b1;
      hc(4);
      r = o_sda;
      hc(4);
      o_scl = 1'b0;
   endtask : bit_io
   task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                       output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], r);
         rx[i] = r;
      end
      bit_io(last, r);
      ack = ~r;
   endtask : xfer
endmodule : ldcr_host
`default_nettype wire

// [verification/tb_ldo_channel_control_regs.sv]
// Self-checking bench for the LDO register bank
`timescale 1ns/10ps
`default_nettype none
`include "ldcr_params.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; \
   $display("unexpected %s exp %h got %h", n, e, s); end end
module tb_ldo_channel_control_regs;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic [3:0] pok = 4'h0;
   logic [3:0] flt = 4'h0;
   logic scl, sda_o, sda_oe;
   wire logic sda;
   logic [3:0] en, dis, lq, irq;
   logic [11:0] dly;
   logic [23:0] vc;
   logic [7:0] va [4] = '{`LDCR_LDO_A_VOLTAGE_SELECT, `LDCR_LDO_B_VOLTAGE_SELECT,
      `LDCR_LDO_C_VOLTAGE_SELECT, `LDCR_LDO_D_VOLTAGE_SELECT};
   int errors = 0;
   int checks = 0;
   always #5 i_clk = ~i_clk;
   // Open drain: the wire is pulled only while enabled and the value is low
   ldcr_host host_u (.i_clk(i_clk), .i_pull(sda_oe & ~sda_o), .o_scl(scl), .o_sda(sda));
   ldcr_top #(.NUM_CH(4)) dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda),
      .o_sda(sda_o), .o_sda_oe(sda_oe), .i_ldo_power_ok(pok), .i_ldo_fault(flt),
      .o_ldo_enable(en), .o_ldo_discharge(dis), .o_ldo_low_quiescent(lq),
      .o_ldo_delay(dly), .o_ldo_voltage_code(vc), .o_ldo_fault_irq(irq));
   task automatic stop_test();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test
   // Expected readback of a voltage select register
   function automatic logic [7:0] vsel_read(input logic [7:0] v);
      return {2'h0, v[5:0]};
   endfunction : vsel_read
   // Expected readback of a control register
   function automatic logic [7:0] ctrl_read(input logic [7:0] c, input logic p);
      return {c[7:1], p};
   endfunction : ctrl_read
   task automatic head(input logic [7:0] a);
      logic [7:0] rx;
      logic ack;
      host_u.frame_edge(1'b1, 1'b0);
      host_u.xfer({`LDCR_DEVICE_ADDR, 1'b0}, 1'b1, rx, ack);
      `CHK("addr ack", 1'b1, ack)
      host_u.xfer(a, 1'b1, rx, ack);
   endtask : head
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] rx;
      logic ack;
      head(a);
      host_u.xfer(d, 1'b1, rx, ack);
      `CHK("data ack", 1'b1, ack)
      host_u.frame_edge(1'b0, 1'b1);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic ack;
      head(a);
      host_u.frame_edge(1'b1, 1'b0);
      host_u.xfer({`LDCR_DEVICE_ADDR, 1'b1}, 1'b1, d, ack);
      host_u.xfer(8'hFF, 1'b1, d, ack);
      host_u.frame_edge(1'b0, 1'b1);
   endtask : rd
   initial begin
      repeat (100000) @(posedge i_clk);
      errors++;
      stop_test();
   end
   initial begin
      logic [7:0] c, v, r;
      logic [3:0] e0;
      logic ak;
      int g;
      void'($urandom(32'hC6365641));
      repeat (12) @(negedge i_clk);
      i_nrst = 1'b1;
      repeat (4) @(negedge i_clk);
      for (int it = 0; it < 12; it++) begin
         g = it % 4;
         // Corners: discharge alone, then every bit set
         c = (it == 0) ? 8'h40 : (it == 1) ? 8'hFF : 8'($urandom);
         v = (it == 1) ? 8'hFF : 8'($urandom);
         pok = 4'($urandom);
         flt = 4'($urandom);
         wr(va[g], v);
         wr(va[g] + 8'h01, c);
         `CHK("enable", c[7], en[g])
         `CHK("discharge", c[6] & ~c[7], dis[g])
         `CHK("low power", c[5], lq[g])
         `CHK("delay", c[4:2], dly[3*g +: 3])
         `CHK("fault req", c[1] & flt[g], irq[g])
         `CHK("voltage code", v[5:0], vc[6*g +: 6])
         flt = ~flt;
         repeat (6) @(negedge i_clk);
         `CHK("fault req level", c[1] & flt[g], irq[g])
         rd(va[g], r);
         `CHK("vsel read", vsel_read(v), r)
         rd(va[g] + 8'h01, r);
         `CHK("ctrl read", ctrl_read(c, pok[g]), r)
      end
      rd(8'h70, r);
      `CHK("unmapped read", `LDCR_UNMAPPED_READ, r)
      // Burst write: pointer moves from voltage select to control
      head(va[2]);
      host_u.xfer(8'h15, 1'b1, r, ak);
      host_u.xfer(8'hA4, 1'b1, r, ak);
      `CHK("burst data ack", 1'b1, ak)
      host_u.frame_edge(1'b0, 1'b1);
      `CHK("burst voltage code", 6'h15, vc[12 +: 6])
      `CHK("burst enable", 1'b1, en[2])
      // Burst read with master acknowledge after the first byte
      head(va[2]);
      host_u.frame_edge(1'b1, 1'b0);
      host_u.xfer({`LDCR_DEVICE_ADDR, 1'b1}, 1'b1, r, ak);
      `CHK("read addr ack", 1'b1, ak)
      host_u.xfer(8'hFF, 1'b0, r, ak);
      `CHK("burst vsel read", vsel_read(8'h15), r)
      host_u.xfer(8'hFF, 1'b1, r, ak);
      `CHK("burst ctrl read", ctrl_read(8'hA4, pok[2]), r)
      host_u.frame_edge(1'b0, 1'b1);
      // Foreign device address: no acknowledge, write must not land
      e0 = en;
      host_u.frame_edge(1'b1, 1'b0);
      host_u.xfer({`LDCR_DEVICE_ADDR ^ 7'h01, 1'b0}, 1'b1, r, ak);
      `CHK("foreign addr ack", 1'b0, ak)
      host_u.xfer(`LDCR_LDO_C_CONTROL, 1'b1, r, ak);
      host_u.xfer(8'h00, 1'b1, r, ak);
      host_u.frame_edge(1'b0, 1'b1);
      `CHK("enable kept", e0, en)
      i_nrst = 1'b0;
      repeat (3) @(negedge i_clk);
      i_nrst = 1'b1;
      repeat (4) @(negedge i_clk);
      `CHK("enable after reset", 4'h0, en)
      stop_test();
   end
endmodule : tb_ldo_channel_control_regs
`default_nettype wire
